// File: inc/kwd_pkg.sv
package kwd_pkg;
  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFF_WDOG_CFG = 4'h0;
  localparam logic [3:0] OFF_MISC = 4'h1;
  localparam logic [3:0] OFF_INT_STAT = 4'h2;
  localparam logic [3:0] OFF_INT_EN = 4'h3;
  localparam logic [3:0] OFF_INT_CLR = 4'h4;
  localparam logic [3:0] OFF_WDOG_STAT = 4'h5;
  // reset values
  localparam logic [7:0] WDOG_CFG_RESET = 8'h53;
  localparam logic [1:0] INT_EN_RESET = 2'h0;
  // enable key codes
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [4:0] KEY_ENABLE = 5'h0a;
  // field positions
  localparam int MISC_FLAG_BIT = 0;
  localparam int WSTAT_TMO_BIT = 0;
  localparam int INT_TIMEOUT = 0;
  localparam int INT_KEYFAULT = 1;
  localparam int INT_W = 2;
  // divider chain and key fault delay in low-speed ticks
  localparam int DIV_W = 18;
  localparam logic [1:0] KEY_FAULT_TICKS = 2'h3;
  // divider tap exponents, indexed by the time-out select field
  localparam logic [4:0] TAP_EXP [8] = '{
    5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12
  };

  typedef struct packed {
    logic [4:0] key;
    logic [2:0] sel;
  } kwd_wdog_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } kwd_bus_t;

  typedef struct packed {
    logic clear_insn;
    logic halt;
    logic power_down;
    logic always_on;
  } kwd_cpu_t;
endpackage

// File: logic/kwd_watchdog.sv
`timescale 1ns/1ps
// Summary of operation
// - counter runs from the low-speed rc clock, also during power-down
// - divider chain gives time-outs from 2^8 to 2^18 low-speed periods
// - select codes 0..7 pick 2^8,10,12,14,15,16,17,18
// - register-controlled mode: key 10101 stops the watchdog
// - register-controlled mode: key 01010 runs the watchdog
// - always-on mode: either legal key runs it, illegal keys still reset
// - illegal key resets the device after two to three low-speed periods
// - key-fault reset sets bit 0 of the misc control register
// - key-fault flag is cleared only by a software write of zero or by srst_in
// - misc control bits 7..1 always read zero
// - overflow in normal run gives a full reset and sets time-out flag
// - overflow in power-down sets time-out flag, resets only pc and sp
// - key-fault reset, clear instruction or halt zero the count
// - every reset but power-down wake-up reloads control with 0x53
module kwd_watchdog (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic slow_clk_in,
  input wire kwd_pkg::kwd_cpu_t cpu_in,
  input wire kwd_pkg::kwd_bus_t bus_in,
  output logic [kwd_pkg::DATA_W-1:0] rdata_out,
  output logic chip_reset_out,
  output logic warm_reset_out,
  output logic timeout_flag_out,
  output logic key_fault_flag_out,
  output logic irq_out
);
  import kwd_pkg::*;

  // low-speed clock synchroniser and accepted level
  logic [2:0] slow_sync_r;
  logic [2:0] slow_sync_nxt;
  logic slow_lvl_r;
  logic slow_lvl_nxt;
  logic slow_tick;

  // watchdog core state
  kwd_wdog_cfg_t wcfg_r;
  kwd_wdog_cfg_t wcfg_nxt;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic [1:0] fault_cnt_r;
  logic [1:0] fault_cnt_nxt;
  logic tmo_flag_r;
  logic tmo_flag_nxt;
  logic kf_flag_r;
  logic kf_flag_nxt;
  logic chip_rst_r;
  logic warm_rst_r;

  // register file state
  logic [INT_W-1:0] int_stat_r;
  logic [INT_W-1:0] int_stat_nxt;
  logic [INT_W-1:0] int_en_r;
  logic [INT_W-1:0] int_en_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // decoded conditions
  logic key_legal;
  logic wdog_on;
  logic [DIV_W-1:0] tap_mask;
  logic at_tap;
  logic clear_evt;
  logic fault_fire;
  logic ovf;
  logic full_rst;
  logic warm_rst;
  logic wr_cfg;
  logic wr_misc;
  logic wr_int_en;
  logic wr_int_clr;

  // the first stage feeds only the second; an edge counts once the
  // second and third stages agree, so a metastable sample cannot tick
  always_comb begin
    slow_sync_nxt = {slow_sync_r[1:0], slow_clk_in};
    slow_lvl_nxt = slow_lvl_r;
    if (slow_sync_r[1] == slow_sync_r[2]) begin
      slow_lvl_nxt = slow_sync_r[2];
    end
  end

  // one-cycle enable per low-speed rising edge; a clock already high at
  // reset release gives one early tick, harmless as the count is zero
  assign slow_tick = (slow_sync_r[1] == slow_sync_r[2]) &&
                     slow_sync_r[2] && !slow_lvl_r;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      slow_sync_r <= 3'h0;
      slow_lvl_r <= 1'b0;
    end else begin
      slow_sync_r <= slow_sync_nxt;
      slow_lvl_r <= slow_lvl_nxt;
    end
  end

  // bus write decode
  assign wr_cfg = bus_in.wr && (bus_in.addr == OFF_WDOG_CFG);
  assign wr_misc = bus_in.wr && (bus_in.addr == OFF_MISC);
  assign wr_int_en = bus_in.wr && (bus_in.addr == OFF_INT_EN);
  assign wr_int_clr = bus_in.wr && (bus_in.addr == OFF_INT_CLR);

  // key check runs every cycle, not only on writes, so a key upset by
  // noise is caught as well as a bad software write
  assign key_legal = (wcfg_r.key == KEY_ENABLE) ||
                     (wcfg_r.key == KEY_DISABLE);
  assign wdog_on = cpu_in.always_on ? key_legal
                 : (wcfg_r.key == KEY_ENABLE);

  // mask of the chosen tap; exponent 18 shifts all ones out
  assign tap_mask = ~({DIV_W{1'b1}} << TAP_EXP[wcfg_r.sel]);
  assign at_tap = (div_r & tap_mask) == tap_mask;

  // fault fires on the third tick seen while illegal, which lands two to
  // three low-speed periods after the key went bad
  assign fault_fire = slow_tick && !key_legal &&
                      (fault_cnt_r == KEY_FAULT_TICKS - 2'h1);
  assign clear_evt = cpu_in.clear_insn || cpu_in.halt;
  // a clear in the overflow cycle wins: software was just in time
  assign ovf = slow_tick && wdog_on && at_tap && !clear_evt && !fault_fire;
  assign full_rst = fault_fire || (ovf && !cpu_in.power_down);
  assign warm_rst = ovf && cpu_in.power_down;

  // key fault tick counter
  always_comb begin
    fault_cnt_nxt = fault_cnt_r;
    if (key_legal || fault_fire) begin
      fault_cnt_nxt = 2'h0;
    end else if (slow_tick) begin
      fault_cnt_nxt = fault_cnt_r + 2'h1;
    end
  end

  // divider chain; a stopped watchdog is held at zero
  always_comb begin
    div_nxt = div_r;
    if (clear_evt || full_rst || !wdog_on) begin
      div_nxt = '0;
    end else if (ovf) begin
      div_nxt = '0;
    end else if (slow_tick) begin
      div_nxt = div_r + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // control register: a full reset reloads it, a warm reset does not
  always_comb begin
    wcfg_nxt = wcfg_r;
    if (wr_cfg) begin
      wcfg_nxt = kwd_wdog_cfg_t'(bus_in.wdata);
    end
    if (full_rst) begin
      wcfg_nxt = kwd_wdog_cfg_t'(WDOG_CFG_RESET);
    end
  end

  // sticky flags: the key-fault set wins over a software clear in the same cycle; a clear event blocks ovf
  always_comb begin
    tmo_flag_nxt = tmo_flag_r;
    if (clear_evt) begin
      tmo_flag_nxt = 1'b0;
    end
    if (ovf) begin
      tmo_flag_nxt = 1'b1;
    end
    kf_flag_nxt = kf_flag_r;
    if (wr_misc) begin
      kf_flag_nxt = bus_in.wdata[MISC_FLAG_BIT];
    end
    if (fault_fire) begin
      kf_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      wcfg_r <= kwd_wdog_cfg_t'(WDOG_CFG_RESET);
      div_r <= '0;
      fault_cnt_r <= 2'h0;
      tmo_flag_r <= 1'b0;
      kf_flag_r <= 1'b0;
      chip_rst_r <= 1'b0;
      warm_rst_r <= 1'b0;
    end else begin
      wcfg_r <= wcfg_nxt;
      div_r <= div_nxt;
      fault_cnt_r <= fault_cnt_nxt;
      tmo_flag_r <= tmo_flag_nxt;
      kf_flag_r <= kf_flag_nxt;
      chip_rst_r <= full_rst;
      warm_rst_r <= warm_rst;
    end
  end

  // interrupt status, enable and read-back
  always_comb begin
    int_stat_nxt = int_stat_r;
    if (wr_int_clr) begin
      int_stat_nxt = int_stat_r & ~bus_in.wdata[INT_W-1:0];
    end
    int_stat_nxt[INT_TIMEOUT] = int_stat_nxt[INT_TIMEOUT] | ovf;
    int_stat_nxt[INT_KEYFAULT] = int_stat_nxt[INT_KEYFAULT] | fault_fire;
    int_en_nxt = int_en_r;
    if (wr_int_en) begin
      int_en_nxt = bus_in.wdata[INT_W-1:0];
    end
  end

  // read data stand only in the cycle after the strobe
  always_comb begin
    rdata_nxt = '0;
    if (bus_in.rd) begin
      case (bus_in.addr)
        OFF_WDOG_CFG: rdata_nxt = wcfg_r;
        OFF_MISC: rdata_nxt = {7'h00, kf_flag_r};
        OFF_INT_STAT: rdata_nxt = {{(DATA_W-INT_W){1'b0}}, int_stat_r};
        OFF_INT_EN: rdata_nxt = {{(DATA_W-INT_W){1'b0}}, int_en_r};
        OFF_WDOG_STAT: rdata_nxt = {7'h00, tmo_flag_r};
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      int_stat_r <= '0;
      int_en_r <= INT_EN_RESET;
      rdata_r <= '0;
    end else begin
      int_stat_r <= int_stat_nxt;
      int_en_r <= int_en_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // outputs
  assign rdata_out = rdata_r;
  assign chip_reset_out = chip_rst_r;
  assign warm_reset_out = warm_rst_r;
  assign timeout_flag_out = tmo_flag_r;
  assign key_fault_flag_out = kf_flag_r;
  assign irq_out = |(int_stat_r & int_en_r);

  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  a_tick_single: assert property (
    slow_tick |=> !slow_tick [*2]
  ) else $error("low-speed tick longer than one cycle");

  a_disabled_hold: assert property (
    (!cpu_in.always_on && wcfg_r.key == KEY_DISABLE) |=> div_r == '0
  ) else $error("disabled watchdog still counting");

  a_enabled_count: assert property (
    (slow_tick && wdog_on && !clear_evt && !at_tap && !fault_fire)
      |=> div_r == $past(div_r) + {{(DIV_W-1){1'b0}}, 1'b1}
  ) else $error("enabled watchdog missed a tick");

  a_fault_delay: assert property (
    fault_fire |-> !key_legal && !$past(key_legal) && slow_tick
  ) else $error("key fault without an illegal key");

  a_legal_no_fault: assert property (
    key_legal |-> !fault_fire
  ) else $error("key fault raised with a legal key");

  a_fault_flag: assert property (
    fault_fire |=> chip_reset_out && key_fault_flag_out &&
                   wcfg_r == kwd_wdog_cfg_t'(WDOG_CFG_RESET)
  ) else $error("key fault did not reset or set the flag");

  a_flag_sticky: assert property (
    (kf_flag_r && !wr_misc) |=> kf_flag_r
  ) else $error("key-fault flag cleared by hardware");

  a_misc_upper: assert property (
    (bus_in.rd && bus_in.addr == OFF_MISC) |=> rdata_out[7:1] == 7'h00
  ) else $error("unimplemented misc bits read nonzero");

  a_ovf_full: assert property (
    (ovf && !cpu_in.power_down) |=> chip_reset_out && timeout_flag_out &&
                                    !warm_reset_out
  ) else $error("normal overflow did not give a full reset");

  a_ovf_warm: assert property (
    (ovf && cpu_in.power_down) |=> warm_reset_out && !chip_reset_out &&
                                   timeout_flag_out && $stable(wcfg_r)
  ) else $error("power-down overflow reset too much");

  // a warm reset must leave the key-fault flag alone
  a_warm_keep: assert property (
    (warm_rst && !wr_misc) |=> $stable(kf_flag_r)
  ) else $error("warm reset disturbed the key-fault flag");

  a_clear_zero: assert property (
    clear_evt |=> div_r == '0 && !chip_reset_out
  ) else $error("clear event left the count running");

  a_halt_tmo: assert property (
    cpu_in.halt |=> !timeout_flag_out
  ) else $error("halt left the time-out flag set");

  a_reset_load: assert property (
    @(posedge sys_clk_in) disable iff (1'b0)
    srst_in |=> wcfg_r == kwd_wdog_cfg_t'(WDOG_CFG_RESET)
  ) else $error("control register not reloaded on reset");

  a_full_reload: assert property (
    full_rst |=> wcfg_r == kwd_wdog_cfg_t'(WDOG_CFG_RESET)
  ) else $error("internal full reset kept the control register");

  a_ovf_tap: assert property (
    ovf |-> (div_r & tap_mask) == tap_mask ##1 div_r == '0
  ) else $error("overflow not at chosen tap");

  // interrupt status must record both events, whatever the enables say
  a_int_tmo_set: assert property (
    ovf |=> int_stat_r[INT_TIMEOUT]
  ) else $error("overflow did not set its interrupt status");

  a_int_kf_set: assert property (
    fault_fire |=> int_stat_r[INT_KEYFAULT]
  ) else $error("key fault did not set its interrupt status");
endmodule

// File: tb/keyed_watchdog_timer_tb_top.sv
`timescale 1ns/1ps
module keyed_watchdog_timer_tb_top;
  import kwd_pkg::*;
  `define CHK(nm, ex, got) begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
    end \
  end
  localparam int TICK = 16; // sys cycles per low-speed period
  localparam int CEIL = 80000; // all tests take about 39k cycles
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic slow_clk_in = 1'b0;
  logic [3:0] div_cnt = 4'h0;
  kwd_cpu_t cpu = '0;
  kwd_bus_t bus = '0;
  logic [7:0] rdata;
  logic chip_rst, warm_rst, tmo_flag, kf_flag, irq;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rst_cnt = 0;
  int n, snap;
  logic [7:0] d;

  kwd_watchdog i_dut (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .slow_clk_in(slow_clk_in),
    .cpu_in(cpu), .bus_in(bus), .rdata_out(rdata),
    .chip_reset_out(chip_rst), .warm_reset_out(warm_rst),
    .timeout_flag_out(tmo_flag), .key_fault_flag_out(kf_flag),
    .irq_out(irq)
  );

  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  // fast low-speed clock keeps overflow runs short; also hang guard
  always @(posedge sys_clk_in) begin
    div_cnt <= div_cnt + 4'h1;
    slow_clk_in <= div_cnt[3];
    cyc <= cyc + 1;
    if (chip_rst | warm_rst) begin
      rst_cnt <= rst_cnt + 1;
    end
    if (cyc == CEIL) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one-cycle strobes; a clear pulse may ride along to zero the chain
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v,
                        input logic clr = 1'b0);
    @(posedge sys_clk_in);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    cpu.clear_insn <= clr;
    @(posedge sys_clk_in);
    bus <= '0;
    cpu.clear_insn <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_in);
    bus <= '0;
    #1 v = rdata;
  endtask

  // cycles until a reset pulse appears, bounded
  task automatic wait_rst(output int k);
    k = 0;
    while (!(chip_rst | warm_rst) && k < 20000) begin
      @(posedge sys_clk_in);
      #1 k++;
    end
  endtask

  task automatic chk_rd(input string nm, input logic [3:0] a,
                        input logic [7:0] ex);
    logic [7:0] v;
    reg_rd(a, v);
    `CHK(nm, ex, v)
  endtask

  task automatic chk_span(input int k, input int lo, input int hi);
    `CHK("span", 1'b1, (k >= lo && k <= hi))
  endtask

  task automatic pulse_halt();
    @(posedge sys_clk_in);
    cpu.halt <= 1'b1;
    @(posedge sys_clk_in);
    cpu.halt <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    chk_rd("cfg", OFF_WDOG_CFG, WDOG_CFG_RESET);
    chk_rd("misc", OFF_MISC, 8'h00);
    chk_rd("unmapped", 4'hf, 8'h00);
    reg_wr(OFF_MISC, 8'hfe);
    chk_rd("misc hi", OFF_MISC, 8'h00);
    // normal overflow at 2^8 ticks, interrupt masked first
    reg_wr(OFF_WDOG_CFG, {KEY_ENABLE, 3'h0}, 1'b1);
    wait_rst(n);
    chk_span(n, 256 * TICK - 24, 256 * TICK + 24);
    `CHK("chip", 1'b1, chip_rst)
    @(posedge sys_clk_in);
    #1 `CHK("tmo", 1'b1, tmo_flag)
    `CHK("irq off", 1'b0, irq)
    chk_rd("cfg ovf", OFF_WDOG_CFG, WDOG_CFG_RESET);
    chk_rd("stat", OFF_INT_STAT, 8'h01);
    reg_wr(OFF_INT_EN, 8'h01);
    `CHK("irq on", 1'b1, irq)
    reg_wr(OFF_INT_CLR, 8'h01);
    `CHK("irq clr", 1'b0, irq)
    pulse_halt();
    `CHK("tmo halt", 1'b0, tmo_flag)
    // disabled by key: no reset over more than one period
    snap = rst_cnt;
    reg_wr(OFF_WDOG_CFG, {KEY_DISABLE, 3'h0}, 1'b1);
    repeat (300 * TICK) @(posedge sys_clk_in);
    `CHK("dis", snap, rst_cnt)
    // periodic clear instruction keeps it from overflowing
    reg_wr(OFF_WDOG_CFG, {KEY_ENABLE, 3'h0}, 1'b1);
    repeat (3) begin
      repeat (200 * TICK) @(posedge sys_clk_in);
      reg_wr(4'h0f, 8'h00, 1'b1);
    end
    `CHK("clr", snap, rst_cnt)
    // power-down overflow at 2^10: warm reset, control kept
    @(posedge sys_clk_in);
    cpu.power_down <= 1'b1;
    reg_wr(OFF_WDOG_CFG, {KEY_ENABLE, 3'h1}, 1'b1);
    wait_rst(n);
    chk_span(n, 1024 * TICK - 24, 1024 * TICK + 24);
    `CHK("warm", 2'b01, {chip_rst, warm_rst})
    @(posedge sys_clk_in);
    cpu.power_down <= 1'b0;
    chk_rd("cfg pd", OFF_WDOG_CFG, {KEY_ENABLE, 3'h1});
    `CHK("tmo pd", 1'b1, tmo_flag)
    chk_rd("wstat", OFF_WDOG_STAT, 8'h01);
    // always-on option ignores the disable key
    @(posedge sys_clk_in);
    cpu.always_on <= 1'b1;
    reg_wr(OFF_WDOG_CFG, {KEY_DISABLE, 3'h0}, 1'b1);
    wait_rst(n);
    chk_span(n, 256 * TICK - 24, 256 * TICK + 24);
    @(posedge sys_clk_in);
    cpu.always_on <= 1'b0;
    // illegal key: reset after two to three low-speed periods
    reg_wr(OFF_INT_CLR, 8'h03);
    reg_wr(OFF_INT_EN, 8'h02);
    `CHK("irq pre", 1'b0, irq)
    chk_rd("int en", OFF_INT_EN, 8'h02);
    reg_wr(OFF_WDOG_CFG, 8'h00);
    wait_rst(n);
    chk_span(n, 2 * TICK - 8, 3 * TICK + 12);
    `CHK("chip key", 1'b1, chip_rst)
    @(posedge sys_clk_in);
    #1 `CHK("kf", 1'b1, kf_flag)
    `CHK("irq kf", 1'b1, irq)
    chk_rd("misc kf", OFF_MISC, 8'h01);
    chk_rd("cfg kf", OFF_WDOG_CFG, WDOG_CFG_RESET);
    pulse_halt();
    `CHK("kf halt", 1'b1, kf_flag)
    reg_wr(OFF_MISC, 8'h00);
    chk_rd("misc sw", OFF_MISC, 8'h00);
    // mid-run reset: control reloaded, interrupt enables dropped
    reg_wr(OFF_WDOG_CFG, 8'ha9);
    @(posedge sys_clk_in);
    srst_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    chk_rd("cfg srst", OFF_WDOG_CFG, WDOG_CFG_RESET);
    `CHK("irq srst", 1'b0, irq)
    give_verdict();
  end
endmodule
